// ---- jbia_defines.vh ----
`ifndef JBIA_DEFINES_VH
`define JBIA_DEFINES_VH

// Instruction codes, 16-bit instruction register
`define JBIA_IR_W          16
`define JBIA_IR_EXTEST     16'h0000
`define JBIA_IR_SAMPLE     16'h0002
`define JBIA_IR_IDCODE     16'h0004
`define JBIA_IR_BYPASS     16'hffff
`define JBIA_IR_FLASH_CTL  16'h0082
`define JBIA_IR_FLASH_DAT  16'h0083
`define JBIA_IR_FLASH_ADR  16'h0084
`define JBIA_IR_CAPTURE    16'h0001
`define JBIA_IR_RESET      16'h0004

// Boundary segment: positions 90 to 137, ports 5 to 7
`define JBIA_BSR_FIRST     90
`define JBIA_BSR_W         48
`define JBIA_PIN_W         24

// Indirect data register layout
`define JBIA_IND_W         20
`define JBIA_IND_OP_HI     19
`define JBIA_IND_OP_LO     18
`define JBIA_IND_PAY_W     18
`define JBIA_OP_READ       2'h2
`define JBIA_OP_WRITE      2'h3

// Target selects for the indirect registers
`define JBIA_SEL_CTL       2'h0
`define JBIA_SEL_DAT       2'h1
`define JBIA_SEL_ADR       2'h2

// Register port
`define JBIA_REG_STATUS    2'h0
`define JBIA_REG_CTRL      2'h1
`define JBIA_CTRL_RESET    8'h01

`endif

// ---- jbia_tap.v ----
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "jbia_defines.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1 - Even cells 90-104 hold port-5 enables, odd cells 91-105 port-5 data.
// RQ2 - Even cells 106-120 hold port-6 enables, odd cells 107-121 port-6 data.
// RQ3 - Even cells 122-136 hold port-7 enables, odd cells 123-137 port-7 data.
// RQ4 - External test captures and updates; sample only captures.
// RQ5 - During external test every input to the core reads as one.
// RQ6 - Bypass instruction puts the one-stage bypass register between TDI and TDO.
// RQ7 - Identity instruction selects the 32-bit device identity register.
// RQ8 - Host loads the selection code before shifting an indirect command.
// RQ9 - Inbound command is 20 bits: opcode in 19:18, payload in 17:0.
// RQ10 - Opcode 0x polls, 10 reads, 11 writes.
// RQ11 - Poll captures but never updates; one-bit shift shows busy.
// RQ12 - A read starts after just the two opcode bits; host then polls.
// RQ13 - Writes carry up to 18 bits, left-justified at bit 17.
// RQ14 - Host polls busy after a write before the next operation.
// RQ15 - Host keeps the instruction unchanged while an operation is busy.
// RQ16 - Outbound word: zero in 19, read payload in 18:1, busy in 0.
// RQ17 - Busy rises when an operation starts and falls when it completes.
// RQ18 - Commands while busy are held and start when busy is read low.
// RQ19 - After busy reads low the next 18 bits give the right-justified result.
// RQ20 - Instruction register is 16 bits and selects the data register.
// RQ21 - Boundary register is one serial shift chain over the pin cells.
module jbia_tap #(
   parameter [31:0] DEVICE_ID = 32'h0a5c_3e11 // Arbitrary value, bit 0 set
)(
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_rst,
   // Test access pins
   input  wire        i_tck,
   input  wire        i_tms,
   input  wire        i_tdi,
   output reg         o_tdo,
   output reg         o_tdo_oe,
   // Core side of ports 5 to 7
   input  wire [23:0] i_core_oe,
   input  wire [23:0] i_core_out,
   output reg  [23:0] o_core_in,
   // Pin side of ports 5 to 7
   input  wire [23:0] i_pin_in,
   output reg  [23:0] o_pin_oe,
   output reg  [23:0] o_pin_out,
   // Indirect flash register target
   output reg         o_ind_req,
   output reg         o_ind_write,
   output reg  [1:0]  o_ind_sel,
   output reg  [17:0] o_ind_wdata,
   input  wire        i_ind_done,
   input  wire [17:0] i_ind_rdata,
   // Register port
   input  wire [1:0]  i_reg_addr,
   input  wire [7:0]  i_reg_wdata,
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   output reg  [7:0]  o_reg_rdata
);

   // One-hot TAP controller states
   localparam [15:0] S_TLR   = 16'h0001;
   localparam [15:0] S_RTI   = 16'h0002;
   localparam [15:0] S_SELDR = 16'h0004;
   localparam [15:0] S_CAPDR = 16'h0008;
   localparam [15:0] S_SHDR  = 16'h0010;
   localparam [15:0] S_EX1DR = 16'h0020;
   localparam [15:0] S_PADR  = 16'h0040;
   localparam [15:0] S_EX2DR = 16'h0080;
   localparam [15:0] S_UPDR  = 16'h0100;
   localparam [15:0] S_SELIR = 16'h0200;
   localparam [15:0] S_CAPIR = 16'h0400;
   localparam [15:0] S_SHIR  = 16'h0800;
   localparam [15:0] S_EX1IR = 16'h1000;
   localparam [15:0] S_PAIR  = 16'h2000;
   localparam [15:0] S_EX2IR = 16'h4000;
   localparam [15:0] S_UPIR  = 16'h8000;

   reg  [2:0]  tck_sync;
   reg  [1:0]  tms_sync, tdi_sync;
   reg  [23:0] pin_s1, pin_s2;
   reg  [15:0] state, next_state, ir, ir_sr;
   reg  [47:0] bsr_sr, bsr_upd;
   reg  [31:0] id_sr;
   reg  [19:0] ind_sr, pend_cmd;
   reg  [17:0] read_payload;
   reg  [7:0]  ctrl;
   reg         byp_sr, ind_busy, ind_pending, dr_lsb;
   wire [47:0] bsr_cap;
   wire        tck_rise, tck_fall, tms, tdi;
   wire        extest_active, sample_active, bsr_sel, id_sel, ind_sel, ind_enable;
   wire [1:0]  next_target, indirect_operation_code;

   //////////////////////////////////////////////////////////////////////////
   // Synchronisers; port pins run through reset so the core never sees stale zeros after it
   always @(posedge i_core_clk)
   begin
      pin_s1 <= i_pin_in;
      pin_s2 <= pin_s1;
      if (i_rst)
      begin
         tck_sync <= 3'h0;
         tms_sync <= 2'h3;
         tdi_sync <= 2'h3;
      end
      else
      begin
         tck_sync <= {tck_sync[1:0], i_tck};
         tms_sync <= {tms_sync[0], i_tms};
         tdi_sync <= {tdi_sync[0], i_tdi};
      end
   end

   assign tck_rise = tck_sync[1] & ~tck_sync[2];
   assign tck_fall = ~tck_sync[1] & tck_sync[2];
   assign tms      = tms_sync[1];
   assign tdi      = tdi_sync[1];

   //////////////////////////////////////////////////////////////////////////
   // Instruction decode
   // RQ20 selection by instruction code
   assign extest_active = (ir == `JBIA_IR_EXTEST);
   assign sample_active = (ir == `JBIA_IR_SAMPLE);
   assign bsr_sel       = extest_active | sample_active;
   assign id_sel        = (ir == `JBIA_IR_IDCODE);
   assign ind_sel       = (ir == `JBIA_IR_FLASH_CTL) | (ir == `JBIA_IR_FLASH_DAT) | (ir == `JBIA_IR_FLASH_ADR);
   assign next_target   = (ir == `JBIA_IR_FLASH_CTL) ? `JBIA_SEL_CTL :
                          (ir == `JBIA_IR_FLASH_DAT) ? `JBIA_SEL_DAT : `JBIA_SEL_ADR;
   assign ind_enable    = ctrl[0];
   // RQ9 opcode sits in the top two bits
   assign indirect_operation_code = ind_sr[`JBIA_IND_OP_HI:`JBIA_IND_OP_LO];

   //////////////////////////////////////////////////////////////////////////
   // TAP controller next state
   always @*
   begin
      case (state)
         S_TLR:   next_state = tms ? S_TLR   : S_RTI;
         S_RTI:   next_state = tms ? S_SELDR : S_RTI;
         S_SELDR: next_state = tms ? S_SELIR : S_CAPDR;
         S_CAPDR: next_state = tms ? S_EX1DR : S_SHDR;
         S_SHDR:  next_state = tms ? S_EX1DR : S_SHDR;
         S_EX1DR: next_state = tms ? S_UPDR  : S_PADR;
         S_PADR:  next_state = tms ? S_EX2DR : S_PADR;
         S_EX2DR: next_state = tms ? S_UPDR  : S_SHDR;
         S_UPDR:  next_state = tms ? S_SELDR : S_RTI;
         S_SELIR: next_state = tms ? S_TLR   : S_CAPIR;
         S_CAPIR: next_state = tms ? S_EX1IR : S_SHIR;
         S_SHIR:  next_state = tms ? S_EX1IR : S_SHIR;
         S_EX1IR: next_state = tms ? S_UPIR  : S_PAIR;
         S_PAIR:  next_state = tms ? S_EX2IR : S_PAIR;
         S_EX2IR: next_state = tms ? S_UPIR  : S_SHIR;
         S_UPIR:  next_state = tms ? S_SELDR : S_RTI;
         default: next_state = S_TLR;
      endcase
   end

   // Serial bit presented on TDO for the selected data register
   always @*
   begin
      if (bsr_sel)
         dr_lsb = bsr_sr[0];
      else if (id_sel)
         dr_lsb = id_sr[0];
      else if (ind_sel)
         dr_lsb = ind_sr[0];
      else
         dr_lsb = byp_sr;
   end

   //////////////////////////////////////////////////////////////////////////
   // TAP actions, shift chains and the indirect engine
   always @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         state        <= S_TLR;
         ir           <= `JBIA_IR_RESET;
         ir_sr        <= `JBIA_IR_CAPTURE;
         bsr_sr       <= 48'h000000000000;
         bsr_upd      <= 48'h000000000000;
         id_sr        <= 32'h00000000;
         byp_sr       <= 1'b0;
         ind_sr       <= 20'h00000;
         read_payload <= 18'h00000;
         ind_busy     <= 1'b0;
         ind_pending  <= 1'b0;
         pend_cmd     <= 20'h00000;
         o_ind_req    <= 1'b0;
         o_ind_write  <= 1'b0;
         o_ind_sel    <= `JBIA_SEL_CTL;
         o_ind_wdata  <= 18'h00000;
         o_tdo        <= 1'b0;
         o_tdo_oe     <= 1'b0;
      end
      else
      begin
         o_ind_req <= 1'b0;
         // RQ17 completion drops busy and keeps the result
         if (i_ind_done && ind_busy)
         begin
            ind_busy     <= 1'b0;
            read_payload <= i_ind_rdata;
         end
         // TDO changes on the falling TCK edge so the host samples it stable
         if (tck_fall)
         begin
            o_tdo    <= (state == S_SHIR) ? ir_sr[0] : dr_lsb;
            o_tdo_oe <= (state == S_SHIR) | (state == S_SHDR);
         end
         if (tck_rise)
         begin
            state <= next_state;
            case (state)
               S_TLR:
                  ir <= `JBIA_IR_RESET;
               S_CAPIR:
                  ir_sr <= `JBIA_IR_CAPTURE;
               S_SHIR:
                  ir_sr <= {tdi, ir_sr[15:1]};
               S_UPIR:
                  ir <= ir_sr;
               S_CAPDR:
               begin
                  // RQ4 both boundary instructions capture
                  bsr_sr <= bsr_cap;
                  // RQ7 identity register loads for shift-out
                  id_sr  <= DEVICE_ID;
                  // RQ6 bypass stage captures zero
                  byp_sr <= 1'b0;
                  // RQ16 outbound word layout
                  ind_sr <= {1'b0, read_payload, ind_busy};
                  // RQ18 held command starts once busy is read low
                  if (ind_sel && ind_pending && !ind_busy)
                  begin
                     ind_pending <= 1'b0;
                     ind_busy    <= 1'b1;
                     o_ind_req   <= 1'b1;
                     o_ind_write <= pend_cmd[`JBIA_IND_OP_LO];
                     o_ind_wdata <= pend_cmd[17:0];
                     o_ind_sel   <= next_target;
                  end
               end
               S_SHDR:
               begin
                  // RQ21 one serial boundary chain
                  bsr_sr <= {tdi, bsr_sr[47:1]};
                  id_sr  <= {tdi, id_sr[31:1]};
                  byp_sr <= tdi;
                  // RQ19 result bits follow busy out of bit 0
                  ind_sr <= {tdi, ind_sr[19:1]};
               end
               S_UPDR:
               begin
                  // RQ4 only external test drives the update stage
                  if (extest_active)
                     bsr_upd <= bsr_sr;
                  // RQ10 RQ11 only 10 and 11 reach the target
                  if (ind_sel && ind_enable && indirect_operation_code[1])
                  begin
                     // RQ18 a busy engine only remembers the command
                     if (ind_busy)
                     begin
                        ind_pending <= 1'b1;
                        pend_cmd    <= ind_sr;
                     end
                     else
                     begin
                        // RQ12 RQ13 start with the payload already at 17:0
                        ind_busy    <= 1'b1;
                        o_ind_req   <= 1'b1;
                        o_ind_write <= indirect_operation_code[0];
                        o_ind_wdata <= ind_sr[17:0];
                        o_ind_sel   <= next_target;
                     end
                  end
               end
               default:
                  ir <= ir;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Boundary cells: cell 2i is the enable, cell 2i+1 the data of pin i
   genvar gi;
   generate
      for (gi = 0; gi < `JBIA_PIN_W; gi = gi + 1)
      begin : g_cell
         // RQ1 RQ2 RQ3 capture enables from core, data from the pin
         assign bsr_cap[2*gi]   = i_core_oe[gi];
         assign bsr_cap[2*gi+1] = pin_s2[gi];
         always @(posedge i_core_clk)
         begin
            if (i_rst)
            begin
               o_pin_oe[gi]  <= 1'b0;
               o_pin_out[gi] <= 1'b0;
               o_core_in[gi] <= 1'b1;
            end
            else
            begin
               // RQ1 RQ2 RQ3 update stage drives the pins in external test
               o_pin_oe[gi]  <= extest_active ? bsr_upd[2*gi]   : i_core_oe[gi];
               o_pin_out[gi] <= extest_active ? bsr_upd[2*gi+1] : i_core_out[gi];
               // RQ5 core sees ones so pin values stay out of it
               o_core_in[gi] <= extest_active ? 1'b1 : pin_s2[gi];
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // Register port: control steers the indirect engine, status shows it
   always @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         ctrl        <= `JBIA_CTRL_RESET;
         o_reg_rdata <= 8'h00;
      end
      else
      begin
         if (i_reg_wr && (i_reg_addr == `JBIA_REG_CTRL))
            ctrl <= {7'h00, i_reg_wdata[0]};
         if (i_reg_rd && (i_reg_addr == `JBIA_REG_STATUS))
            o_reg_rdata <= {4'h0, ind_pending, ind_busy, extest_active, ind_sel};
         else if (i_reg_rd && (i_reg_addr == `JBIA_REG_CTRL))
            o_reg_rdata <= ctrl;
         else
            o_reg_rdata <= 8'h00; // Unmapped reads and idle cycles give zero
      end
   end

endmodule

// ---- jbia_tap_chk.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module jbia_chk (
   // Clock and reset
   input wire        i_core_clk,
   input wire        i_rst,
   // Watched ports
   input wire        i_tck,
   input wire [23:0] i_pin_in,
   input wire [23:0] o_core_in,
   input wire        o_tdo,
   input wire        o_tdo_oe,
   input wire        o_ind_req,
   input wire        o_ind_write,
   input wire [1:0]  o_ind_sel,
   input wire [17:0] o_ind_wdata,
   input wire        i_reg_rd,
   input wire [1:0]  i_reg_addr,
   input wire [7:0]  o_reg_rdata
);
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   chk_req_pulse: assert property (o_ind_req |=> !o_ind_req)
      else $error("start pulse longer than one cycle");
   chk_cmd_stands: assert property (o_ind_req |=> $stable({o_ind_write, o_ind_sel, o_ind_wdata})[*8])
      else $error("command fields moved after start");
   chk_core_lag: assert property (o_core_in != 24'hffffff |-> o_core_in == $past(i_pin_in, 3))
      else $error("core input neither forced high nor pin value");
   // Sync chain delay means edges show two samples late
   chk_tdo_fall: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
      else $error("data out moved away from a falling test clock");
   chk_oe_fall: assert property ($changed(o_tdo_oe) |-> !$past(i_tck, 2))
      else $error("output enable moved away from a falling test clock");
   chk_rd_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
      else $error("read data present without a read");
   chk_rd_unmapped: assert property ($past(i_reg_rd) && $past(i_reg_addr) > 2'h1 |-> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_status_top: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 2'h0 |-> o_reg_rdata[7:4] == 4'h0)
      else $error("status upper bits not zero");
endmodule
bind jbia_tap jbia_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_tck(i_tck), .i_pin_in(i_pin_in),
   .o_core_in(o_core_in), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_ind_req(o_ind_req), .o_ind_write(o_ind_write),
   .o_ind_sel(o_ind_sel), .o_ind_wdata(o_ind_wdata), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
   .o_reg_rdata(o_reg_rdata));

// ---- jbia_host.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module jbia_host (
   // Test access pins
   output reg  o_tck,
   output reg  o_tms,
   output reg  o_tdi,
   input  wire i_tdo
);
   reg t;
   initial
   begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end
   // One 160 ns period; the clock stands low between frames
   // Non-blocking so a pin change never races the sampling clock edge
   task step(input tms, input tdi);
      begin
         o_tms <= tms;
         o_tdi <= tdi;
         #80 o_tck <= 1'b1;
         t = i_tdo;
         #80 o_tck <= 1'b0;
      end
   endtask
   // Update then idle; the update step drives the data line low, so the idle step leaves it high
   task fin;
      begin
         step(1'b1, 1'b0);
         step(1'b0, ~o_tdi);
      end
   endtask
   // Five ones always reach reset, whatever the state
   task tlr;
      integer k;
      for (k = 0; k < 6; k = k + 1)
         step(k < 5, 1'b0);
   endtask
   task ir(input [15:0] code, output [15:0] c);
      integer k;
      begin
         step(1'b1, 1'b0);
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
         step(1'b0, 1'b0);
         for (k = 0; k < 16; k = k + 1)
         begin
            step(k == 15, code[k]);
            c[k] = t;
         end
         fin;
      end
   endtask
   // short shifts land at the top
   task dr(input integer n, input [63:0] din, output [63:0] q);
      integer k;
      begin
         q = 64'h0;
         step(1'b1, 1'b0);
         step(1'b0, 1'b0);
         step(1'b0, 1'b0);
         for (k = 0; k < n; k = k + 1)
         begin
            step(k == n - 1, din[k]);
            q[k] = t;
         end
         fin;
      end
   endtask
endmodule

// ---- jbia_tap_tb.sv ----
`timescale 1ns/1ps
`include "jbia_defines.vh"
module jbia_tap_tb;
   // Design inputs
   reg         i_core_clk  = 1'b0;
   reg         i_rst       = 1'b1;
   reg  [23:0] i_core_oe   = 24'h5a3c96;
   reg  [23:0] i_core_out  = 24'hc3e1a7;
   reg  [23:0] i_pin_in    = 24'h9d2b64;
   reg         i_ind_done  = 1'b0;
   reg  [17:0] i_ind_rdata = 18'h0;
   reg  [1:0]  i_reg_addr  = 2'h0;
   reg  [7:0]  i_reg_wdata = 8'h0;
   reg         i_reg_wr    = 1'b0;
   reg         i_reg_rd    = 1'b0;
   wire        i_tck;
   wire        i_tms;
   wire        i_tdi;
   // Design outputs
   wire        o_tdo;
   wire        o_tdo_oe;
   wire [23:0] o_core_in;
   wire [23:0] o_pin_oe;
   wire [23:0] o_pin_out;
   wire        o_ind_req;
   wire        o_ind_write;
   wire [1:0]  o_ind_sel;
   wire [17:0] o_ind_wdata;
   wire [7:0]  o_reg_rdata;
   // Bench state
   integer     err_count   = 0;
   integer     checked     = 0;
   integer     reqs        = 0;
   integer     r0;
   reg  [8:0]  tcnt        = 9'h0;
   reg  [17:0] t_rdata     = 18'h0;
   reg  [63:0] v;
   reg  [15:0] cap;
   reg  [7:0]  d;
   localparam [31:0] ID = 32'h5e3a71c1; // Arbitrary value, bit 0 set
   always #10 i_core_clk = ~i_core_clk;
   jbia_tap #(.DEVICE_ID(ID)) uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms),
      .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_core_oe(i_core_oe), .i_core_out(i_core_out),
      .o_core_in(o_core_in), .i_pin_in(i_pin_in), .o_pin_oe(o_pin_oe), .o_pin_out(o_pin_out),
      .o_ind_req(o_ind_req), .o_ind_write(o_ind_write), .o_ind_sel(o_ind_sel), .o_ind_wdata(o_ind_wdata),
      .i_ind_done(i_ind_done), .i_ind_rdata(i_ind_rdata), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
   jbia_host h (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));
   ////////////////////////////////////////////////////////////
   // Flash side: slow answer, 200 cycles; data toggles when not valid
   always @(posedge i_core_clk)
   begin
      i_ind_done <= 1'b0;
      i_ind_rdata <= ~i_ind_rdata;
      if (o_ind_req)
      begin
         tcnt <= 9'd200;
         reqs <= reqs + 1;
      end
      else if (tcnt == 9'd1)
      begin
         tcnt <= 9'd0;
         i_ind_done <= 1'b1;
         i_ind_rdata <= t_rdata;
      end
      else if (tcnt != 9'd0)
         tcnt <= tcnt - 9'd1;
   end
   task check(input [63:0] got, input [63:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks=%0d mismatches=%0d", checked, err_count);
         if (err_count == 0 && checked > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task reg_wr(input [1:0] a, input [7:0] w);
      begin
         @(posedge i_core_clk);
         i_reg_addr <= a;
         i_reg_wdata <= w;
         i_reg_wr <= 1'b1;
         @(posedge i_core_clk);
         i_reg_wr <= 1'b0;
      end
   endtask
   task reg_rd(input [1:0] a);
      begin
         @(posedge i_core_clk);
         i_reg_addr <= a;
         i_reg_rd <= 1'b1;
         @(posedge i_core_clk);
         i_reg_rd <= 1'b0;
         #1 d = o_reg_rdata;
      end
   endtask
   // busy is waited out before any new instruction; t_read sends its second read while the first is busy
   task wait_done;
      integer k;
      begin
         for (k = 0; k < 400 && tcnt != 9'd0; k = k + 1)
            @(posedge i_core_clk);
         check(tcnt, 9'd0);
         repeat (3) @(posedge i_core_clk);
      end
   endtask
   function [47:0] mix(input [23:0] oe, input [23:0] pin);
      integer k;
      for (k = 0; k < 24; k = k + 1)
         {mix[2*k+1], mix[2*k]} = {pin[k], oe[k]};
   endfunction
   ////////////////////////////////////////////////////////////
   task t_scan;
      begin
         h.dr(32, 64'h0, v);
         check(v[31:0], ID);
         h.ir(16'h1234, cap);
         check(cap, 16'h0001);
         h.dr(3, 64'h6, v);
         check(v[2:0], 3'b100);
         h.ir(`JBIA_IR_SAMPLE, cap);
         @(posedge i_core_clk) i_pin_in <= 24'h6b1d93;
         h.dr(48, 64'hffffffffffff, v);
         check(v[47:0], mix(i_core_oe, i_pin_in));
         check(o_pin_out, i_core_out);
         h.ir(`JBIA_IR_EXTEST, cap);
         repeat (3) @(posedge i_core_clk);
         check({o_pin_oe, o_pin_out}, 48'h0);
         check(o_tdo_oe, 1'b0);
         h.dr(48, mix(24'h0f1e2d, 24'hb4c5d6), v);
         repeat (6) @(posedge i_core_clk);
         check({o_pin_oe, o_pin_out}, {24'h0f1e2d, 24'hb4c5d6});
         check(o_core_in, 24'hffffff);
         h.ir(`JBIA_IR_IDCODE, cap);
         repeat (6) @(posedge i_core_clk);
         check({o_pin_oe, o_core_in}, {i_core_oe, i_pin_in});
         $display("scan test done");
      end
   endtask
   task t_write;
      begin
         r0 = reqs;
         h.ir(`JBIA_IR_FLASH_DAT, cap);
         h.dr(10, {2'b11, 8'ha7}, v);
         repeat (6) @(posedge i_core_clk);
         check({o_ind_write, o_ind_sel, o_ind_wdata[17:10]}, {1'b1, `JBIA_SEL_DAT, 8'ha7});
         h.dr(1, 64'h0, v);
         check(v[0], 1'b1);
         reg_rd(`JBIA_REG_STATUS);
         check(d, 8'h05);
         wait_done;
         h.dr(20, {2'b01, 18'h3ffff}, v);
         check(v[0], 1'b0);
         check(reqs, r0 + 1);
         h.ir(`JBIA_IR_FLASH_ADR, cap);
         h.dr(20, {2'b11, 18'h2c35a}, v);
         repeat (6) @(posedge i_core_clk);
         check({o_ind_sel, o_ind_wdata}, {`JBIA_SEL_ADR, 18'h2c35a});
         wait_done;
         $display("write test done");
      end
   endtask
   task t_read;
      begin
         t_rdata = 18'h2a5c3;
         h.ir(`JBIA_IR_FLASH_CTL, cap);
         r0 = reqs;
         h.dr(2, 64'h2, v);
         h.dr(2, 64'h2, v);
         check({reqs, o_ind_write, o_ind_sel}, {r0 + 1, 1'b0, `JBIA_SEL_CTL});
         reg_rd(`JBIA_REG_STATUS);
         check(d, 8'h0d);
         wait_done;
         t_rdata = 18'h001b6;
         h.dr(19, 64'h0, v);
         check(v[18:0], {18'h2a5c3, 1'b0});
         check(reqs, r0 + 2);
         wait_done;
         h.dr(9, 64'h0, v);
         check(v[8:0], {8'hb6, 1'b0});
         reg_wr(`JBIA_REG_CTRL, 8'h00);
         h.dr(2, 64'h2, v);
         reg_rd(2'h2);
         check({reqs, d}, {r0 + 2, 8'h00});
         reg_wr(`JBIA_REG_CTRL, 8'hff);
         reg_rd(`JBIA_REG_CTRL);
         check(d, `JBIA_CTRL_RESET);
         $display("read test done");
      end
   endtask
   // Main sequence
   initial
   begin
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      h.tlr;
      t_scan;
      t_write;
      t_read;
      give_verdict;
   end
   // Watchdog: tests need about 4k cycles, the limit allows 20k
   initial
   begin
      #400000;
      err_count = err_count + 1;
      give_verdict;
   end
endmodule
